// [hw/adcr_pkg.sv]
`default_nettype none
package adcr_pkg;
   // Register selector codes
   localparam logic [1:0] SEL_RESULT = 2'h0;
   localparam logic [1:0] SEL_CONFIG = 2'h1;
   localparam logic [1:0] SEL_LOW = 2'h2;
   localparam logic [1:0] SEL_HIGH = 2'h3;
   // Reset values and full-scale codes
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] CONFIG_RST = 16'h8583;
   localparam logic [15:0] LOW_LIMIT_RST = 16'h8000;
   localparam logic [15:0] HIGH_LIMIT_RST = 16'h7FFF;
   localparam logic [15:0] FULL_SCALE_POS = 16'h7FFF;
   localparam logic [15:0] FULL_SCALE_NEG = 16'h8000;
   // Configuration field positions
   localparam int STATUS_BIT = 15;
   localparam int INPUT_HI = 14;
   localparam int INPUT_LO = 12;
   localparam int GAIN_HI = 11;
   localparam int GAIN_LO = 9;
   localparam int CONT_BIT = 8;
   localparam int RATE_HI = 7;
   localparam int RATE_LO = 5;
   localparam int CMP_TYPE_BIT = 4;
   localparam int POL_BIT = 3;
   localparam int LATCH_BIT = 2;
   localparam int QUEUE_HI = 1;
   localparam int QUEUE_LO = 0;
   // Serial framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] BYTE_ADDR = 3'h0;
   localparam logic [2:0] BYTE_SEL = 3'h1;
   localparam logic [2:0] BYTE_MSB = 3'h2;
   localparam logic [2:0] BYTE_LSB = 3'h3;
   localparam logic [2:0] BYTE_EXTRA = 3'h4;
   // Serial engine states, Gray along the usual path
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RXACK = 3'b011,
      ST_TX = 3'b010,
      ST_TXACK = 3'b110
   } adcr_state_t;
endpackage : adcr_pkg
`default_nettype wire

// [hw/adcr_regs.sv]
// Contract
// - Result is 16-bit two's complement value
// - Full scale codes are 7FFFh and 8000h
// - Out-of-range input saturates, never wraps
// - Four 16-bit registers reached via selector
// - Selector bits 1:0 choose the register
// - Comparatorless variant omits both limit registers
// - Result holds last conversion, zero after reset
// - Result register read-only, writes ignored
// - Configuration resets to 8583h
// - Configuration field layout by bit position
// - Configuration writable and reports device status
// - Status bit starts conversion from power down, reads busy state
// - Selector holds until next write transfer
// - Words travel upper byte first
`default_nettype none
module adcr_regs #(
   parameter logic [6:0] SLAVE_ADDR = 7'h48,
   parameter bit HAS_COMPARATOR = 1'b1,
   parameter int CONV_W = 18
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial pins, open drain data
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe_n,
   // Converter core
   input wire logic convDone,
   input wire logic signed [CONV_W-1:0] convData,
   input wire logic convBusy,
   output logic convStart,
   // Configuration fields
   output logic [2:0] input_select,
   output logic [2:0] gain_range_select,
   output logic continuity_select,
   output logic [2:0] sample_rate_select,
   output logic alert_type,
   output logic alert_polarity,
   output logic alert_latch_enable,
   output logic [1:0] alert_queue_select,
   // Comparator limits and result
   output logic [15:0] low_limit,
   output logic [15:0] high_limit,
   output logic [15:0] conversion_result
);
   // Clip the wide raw sample into the 16-bit code range
   function automatic logic [15:0] saturate(input logic signed [CONV_W-1:0] raw);
      logic signed [CONV_W-1:0] posMax;
      logic signed [CONV_W-1:0] negMax;
      posMax = CONV_W'(signed'(adcr_pkg::FULL_SCALE_POS));
      negMax = -posMax - CONV_W'(1);
      if (raw > posMax) begin
         saturate = adcr_pkg::FULL_SCALE_POS;
      end else if (raw < negMax) begin
         saturate = adcr_pkg::FULL_SCALE_NEG;
      end else begin
         saturate = raw[15:0];
      end
   endfunction : saturate

   logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
   adcr_pkg::adcr_state_t state_reg, state_next;
   logic [3:0] bitCnt_reg, bitCnt_next;
   logic [2:0] byteCnt_reg, byteCnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] hiByte_reg, hiByte_next;
   logic [15:0] snap_reg, snap_next;
   logic readMode_reg, readMode_next;
   logic lowHalf_reg, lowHalf_next;
   logic drive_n_reg, drive_n_next;
   logic [1:0] sel_reg, sel_next;
   logic [15:0] cfg_reg, cfg_next;
   logic [15:0] result_reg, result_next;
   logic [15:0] low_reg, low_next;
   logic [15:0] high_reg, high_next;
   logic start_reg, start_next;
   logic sclRise, sclFall, busStart, busStop, powerDown;
   logic [15:0] readValue;
   logic [15:0] wordIn;

   // Two-stage synchronisers; edges seen only from the second stage onward
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclS1 <= 1'b1;
         sclS2 <= 1'b1;
         sclD <= 1'b1;
         sdaS1 <= 1'b1;
         sdaS2 <= 1'b1;
         sdaD <= 1'b1;
      end else begin
         sclS1 <= sclIn;
         sclS2 <= sclS1;
         sclD <= sclS2;
         sdaS1 <= sdaIn;
         sdaS2 <= sdaS1;
         sdaD <= sdaS2;
      end
   end

   assign sclRise = sclS2 & ~sclD;
   assign sclFall = ~sclS2 & sclD;
   assign busStart = sclS2 & sclD & sdaD & ~sdaS2;
   assign busStop = sclS2 & sclD & ~sdaD & sdaS2;
   assign wordIn = {hiByte_reg, shift_reg};
   // A just-issued start counts as busy so software never sees a stale idle
   assign powerDown = cfg_reg[adcr_pkg::CONT_BIT] & ~convBusy & ~start_reg;

   // Read mux; omitted limits read as zero
   always_comb begin
      unique case (sel_reg)
         adcr_pkg::SEL_RESULT: readValue = result_reg;
         adcr_pkg::SEL_CONFIG: readValue = {powerDown, cfg_reg[14:0]};
         adcr_pkg::SEL_LOW: readValue = HAS_COMPARATOR ? low_reg : 16'h0000;
         adcr_pkg::SEL_HIGH: readValue = HAS_COMPARATOR ? high_reg : 16'h0000;
      endcase
   end

   // Next-state logic for the serial engine and the register bank
   always_comb begin
      state_next = state_reg;
      bitCnt_next = bitCnt_reg;
      byteCnt_next = byteCnt_reg;
      shift_next = shift_reg;
      hiByte_next = hiByte_reg;
      snap_next = snap_reg;
      readMode_next = readMode_reg;
      lowHalf_next = lowHalf_reg;
      drive_n_next = drive_n_reg;
      sel_next = sel_reg;
      cfg_next = cfg_reg;
      result_next = result_reg;
      low_next = low_reg;
      high_next = high_reg;
      start_next = 1'b0;
      if (convDone) begin
         result_next = saturate(convData);
      end
      if (busStop) begin
         state_next = adcr_pkg::ST_IDLE;
         drive_n_next = 1'b1;
      end else if (busStart) begin
         state_next = adcr_pkg::ST_RX;
         bitCnt_next = 4'h0;
         byteCnt_next = adcr_pkg::BYTE_ADDR;
         readMode_next = 1'b0;
         drive_n_next = 1'b1;
      end else begin
         unique case (state_reg)
            adcr_pkg::ST_IDLE: begin
               drive_n_next = 1'b1;
            end
            adcr_pkg::ST_RX: begin
               if (sclRise) begin
                  shift_next = {shift_reg[6:0], sdaS2};
                  bitCnt_next = bitCnt_reg + 4'h1;
               end else if (sclFall && bitCnt_reg == adcr_pkg::BITS_PER_BYTE) begin
                  bitCnt_next = 4'h0;
                  state_next = adcr_pkg::ST_RXACK;
                  drive_n_next = 1'b0;
                  if (byteCnt_reg != adcr_pkg::BYTE_EXTRA) begin
                     byteCnt_next = byteCnt_reg + 3'h1;
                  end
                  unique case (byteCnt_reg)
                     adcr_pkg::BYTE_ADDR: begin
                        if (shift_reg[7:1] != SLAVE_ADDR) begin
                           state_next = adcr_pkg::ST_IDLE;
                           drive_n_next = 1'b1;
                        end
                        readMode_next = shift_reg[0];
                        snap_next = readValue;
                        lowHalf_next = 1'b0;
                     end
                     adcr_pkg::BYTE_SEL: sel_next = shift_reg[1:0];
                     adcr_pkg::BYTE_MSB: hiByte_next = shift_reg;
                     adcr_pkg::BYTE_LSB: begin
                        unique case (sel_reg)
                           adcr_pkg::SEL_RESULT: ;
                           adcr_pkg::SEL_CONFIG: begin
                              cfg_next = {cfg_reg[adcr_pkg::STATUS_BIT], wordIn[14:0]};
                              start_next = wordIn[adcr_pkg::STATUS_BIT] & powerDown;
                           end
                           adcr_pkg::SEL_LOW: if (HAS_COMPARATOR) low_next = wordIn;
                           adcr_pkg::SEL_HIGH: if (HAS_COMPARATOR) high_next = wordIn;
                        endcase
                     end
                     default: ;
                  endcase
               end
            end
            adcr_pkg::ST_RXACK: begin
               if (sclFall) begin
                  if (readMode_reg) begin
                     state_next = adcr_pkg::ST_TX;
                     shift_next = snap_reg[15:8];
                     drive_n_next = snap_reg[15];
                     lowHalf_next = 1'b1;
                  end else begin
                     state_next = adcr_pkg::ST_RX;
                     drive_n_next = 1'b1;
                  end
               end
            end
            adcr_pkg::ST_TX: begin
               if (sclRise) begin
                  bitCnt_next = bitCnt_reg + 4'h1;
               end else if (sclFall) begin
                  if (bitCnt_reg == adcr_pkg::BITS_PER_BYTE) begin
                     state_next = adcr_pkg::ST_TXACK;
                     bitCnt_next = 4'h0;
                     drive_n_next = 1'b1;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_n_next = shift_reg[6];
                  end
               end
            end
            adcr_pkg::ST_TXACK: begin
               // A master that does not acknowledge ends the read
               if (sclRise && sdaS2) begin
                  state_next = adcr_pkg::ST_IDLE;
               end else if (sclFall) begin
                  state_next = adcr_pkg::ST_TX;
                  shift_next = lowHalf_reg ? snap_reg[7:0] : snap_reg[15:8];
                  drive_n_next = lowHalf_reg ? snap_reg[7] : snap_reg[15];
                  lowHalf_next = ~lowHalf_reg;
               end
            end
            default: begin
               state_next = adcr_pkg::ST_IDLE;
               drive_n_next = 1'b1;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= adcr_pkg::ST_IDLE;
         bitCnt_reg <= 4'h0;
         byteCnt_reg <= adcr_pkg::BYTE_ADDR;
         shift_reg <= 8'h00;
         hiByte_reg <= 8'h00;
         snap_reg <= 16'h0000;
         readMode_reg <= 1'b0;
         lowHalf_reg <= 1'b0;
         drive_n_reg <= 1'b1;
         sel_reg <= adcr_pkg::SEL_RESULT;
         cfg_reg <= adcr_pkg::CONFIG_RST;
         result_reg <= adcr_pkg::RESULT_RST;
         low_reg <= adcr_pkg::LOW_LIMIT_RST;
         high_reg <= adcr_pkg::HIGH_LIMIT_RST;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         byteCnt_reg <= byteCnt_next;
         shift_reg <= shift_next;
         hiByte_reg <= hiByte_next;
         snap_reg <= snap_next;
         readMode_reg <= readMode_next;
         lowHalf_reg <= lowHalf_next;
         drive_n_reg <= drive_n_next;
         sel_reg <= sel_next;
         cfg_reg <= cfg_next;
         result_reg <= result_next;
         low_reg <= low_next;
         high_reg <= high_next;
         start_reg <= start_next;
      end
   end

   // Field outputs straight from the configuration flops
   assign sdaOut = 1'b0; // Open drain: only ever pulls low
   assign sdaOe_n = drive_n_reg;
   assign convStart = start_reg;
   assign input_select = cfg_reg[adcr_pkg::INPUT_HI:adcr_pkg::INPUT_LO];
   assign gain_range_select = cfg_reg[adcr_pkg::GAIN_HI:adcr_pkg::GAIN_LO];
   assign continuity_select = cfg_reg[adcr_pkg::CONT_BIT];
   assign sample_rate_select = cfg_reg[adcr_pkg::RATE_HI:adcr_pkg::RATE_LO];
   assign alert_type = cfg_reg[adcr_pkg::CMP_TYPE_BIT];
   assign alert_polarity = cfg_reg[adcr_pkg::POL_BIT];
   assign alert_latch_enable = cfg_reg[adcr_pkg::LATCH_BIT];
   assign alert_queue_select = cfg_reg[adcr_pkg::QUEUE_HI:adcr_pkg::QUEUE_LO];
   assign low_limit = HAS_COMPARATOR ? low_reg : 16'h0000;
   assign high_limit = HAS_COMPARATOR ? high_reg : 16'h0000;
   assign conversion_result = result_reg;
endmodule : adcr_regs
`default_nettype wire

// [testbench/adcr_master.sv]
`default_nettype none
module adcr_master (
   // Clock and device pin
   input wire logic core_clk,
   input wire logic sdaOe_n,
   // Bus wires
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sdaLow = 1'b0;
   // Pull-up on SDA, so a released line reads high
   assign sda = !(sdaLow || !sdaOe_n);
   initial scl = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // One bit in 8 clocks; data moves only while SCL is low
   task automatic bitx(input logic b, output logic r);
      sdaLow = !b;
      tick(2);
      scl = 1'b1;
      tick(3);
      r = sda;
      tick(1);
      scl = 1'b0;
      tick(2);
   endtask : bitx
   task automatic xbyte(input logic [7:0] b, input logic ackIn, output logic [7:0] r,
         output logic ackOut);
      for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
      bitx(ackIn, ackOut);
   endtask : xbyte
   // Whole frame; a read returns two bytes, upper first, and NACKs the last
   task automatic frame(input logic [7:0] a, input logic [7:0] s, inout logic [15:0] d,
         input int nb, output logic nak);
      logic [7:0] r;
      logic k;
      sdaLow = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(2);
      xbyte(a, 1'b1, r, nak);
      if (a[0]) begin
         for (int i = 0; i < 2; i++) begin
            xbyte(8'hFF, 1'(i), r, k);
            d = {d[7:0], r};
         end
      end else begin
         xbyte(s, 1'b1, r, k);
         for (int i = 0; i < nb; i++) xbyte(i == 0 ? d[15:8] : d[7:0], 1'b1, r, k);
      end
      sdaLow = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      sdaLow = 1'b0;
      tick(4);
   endtask : frame
endmodule : adcr_master
`default_nettype wire

// [testbench/adcr_regs_monitor.sv]
`default_nettype none
module adcr_regs_monitor #(
   parameter int CONV_W = 18
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Converter side and outputs
   input wire logic convDone,
   input wire logic signed [CONV_W-1:0] convData,
   input wire logic convBusy,
   input wire logic convStart,
   input wire logic continuity_select,
   input wire logic sdaOut,
   input wire logic [15:0] conversion_result
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Low 16 bits of the raw sample, so that $past sees a plain signal
   logic [15:0] rawLow;
   assign rawLow = convData[15:0];
   // Clipping instead of wrap for out of range samples
   a_clip_high: assert property (convDone && convData > 32767 |=>
      conversion_result == 16'h7FFF) else $error("result not clipped high");
   a_clip_low: assert property (convDone && convData < -32768 |=>
      conversion_result == 16'h8000) else $error("result not clipped low");
   a_result_load: assert property (convDone && convData <= 32767 && convData >= -32768
      |=> conversion_result == $past(rawLow)) else $error("result not loaded");
   a_result_hold: assert property (!convDone |=> $stable(conversion_result))
      else $error("result changed without a conversion");
   a_result_cleared: assert property ($fell(rst) |-> conversion_result == 16'h0000)
      else $error("result not zero after reset");
   a_start_pulse: assert property (convStart |=> !convStart)
      else $error("start longer than one cycle");
   // The start is decided on the mode in force before the write lands
   a_start_mode: assert property (convStart |-> $past(continuity_select && !convBusy))
      else $error("start outside power down");
   a_drain_zero: assert property (1'b1 |-> sdaOut == 1'b0)
      else $error("data pin value not open drain");
endmodule : adcr_regs_monitor
bind adcr_regs adcr_regs_monitor #(.CONV_W(CONV_W)) u_adcr_regs_monitor (
   .core_clk(core_clk), .rst(rst), .convDone(convDone), .convData(convData),
   .convBusy(convBusy), .convStart(convStart), .continuity_select(continuity_select),
   .sdaOut(sdaOut), .conversion_result(conversion_result));
`default_nettype wire

// [testbench/adcr_regs_tb.sv]
`default_nettype none
module adcr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] SA = 7'h48;
   localparam logic [6:0] SB = 7'h4A;
   logic sdaOeNc_n;
   logic [15:0] lowNc, highNc;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic convDone = 1'b0;
   logic convBusy = 1'b0;
   logic signed [17:0] convData = '0;
   logic scl, sda, sdaOut, sdaOe_n, convStart, continuity_select, alert_type, nak;
   logic alert_polarity, alert_latch_enable;
   logic [2:0] input_select, gain_range_select, sample_rate_select;
   logic [1:0] alert_queue_select;
   logic [15:0] low_limit, high_limit, conversion_result, d;
   logic [15:0] mreg [4] = '{16'h0000, 16'h8583, 16'h8000, 16'h7FFF};
   int n_errors = 0, tests_run = 0, startCount = 0, seed = 32'ha06e;
   int tbl [9] = '{131071, -131072, 32767, -32768, 32768, -32769, 0, 1, -1};
   wire logic [14:0] fields = {input_select, gain_range_select, continuity_select,
      sample_rate_select, alert_type, alert_polarity, alert_latch_enable, alert_queue_select};
   initial forever #12.5 core_clk = !core_clk;
   always @(posedge core_clk) if (convStart === 1'b1) startCount++;
   adcr_master mst (.core_clk(core_clk), .sdaOe_n(sdaOe_n & sdaOeNc_n), .scl(scl), .sda(sda));
   adcr_regs #(.SLAVE_ADDR(SA), .HAS_COMPARATOR(1'b1), .CONV_W(18)) u_adcr_regs (
      .core_clk(core_clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe_n(sdaOe_n), .convDone(convDone), .convData(convData), .convBusy(convBusy),
      .convStart(convStart), .input_select(input_select),
      .gain_range_select(gain_range_select), .continuity_select(continuity_select),
      .sample_rate_select(sample_rate_select), .alert_type(alert_type),
      .alert_polarity(alert_polarity), .alert_latch_enable(alert_latch_enable),
      .alert_queue_select(alert_queue_select), .low_limit(low_limit),
      .high_limit(high_limit), .conversion_result(conversion_result));
   // Comparatorless variant on the same bus at another address
   adcr_regs #(.SLAVE_ADDR(SB), .HAS_COMPARATOR(1'b0), .CONV_W(18)) u_adcr_regs_nc (
      .core_clk(core_clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(),
      .sdaOe_n(sdaOeNc_n), .convDone(convDone), .convData(convData), .convBusy(convBusy),
      .convStart(), .input_select(), .gain_range_select(), .continuity_select(),
      .sample_rate_select(), .alert_type(), .alert_polarity(), .alert_latch_enable(),
      .alert_queue_select(), .low_limit(lowNc), .high_limit(highNc),
      .conversion_result());
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // Register outputs must mirror the model after reset, each write and conversion, and the refused frame
   task automatic ports;
      chk("result", mreg[0], conversion_result);
      chk("fields", mreg[1][14:0], {1'b0, fields});
      chk("low", mreg[2], low_limit);
      chk("high", mreg[3], high_limit);
   endtask : ports
   // Status bit is not stored: it reads the live idle state
   task automatic rdreg(input logic [1:0] s, input bit point);
      if (point) mst.frame({SA, 1'b0}, {6'h00, s}, d, 0, nak);
      mst.frame({SA, 1'b1}, 8'h00, d, 0, nak);
      chk("read", s == 2'h1 ? {mreg[1][8] & !convBusy, mreg[1][14:0]} : mreg[s], d);
   endtask : rdreg
   task automatic wrreg(input logic [1:0] s, input logic [15:0] v);
      d = v;
      mst.frame({SA, 1'b0}, {6'h00, s}, d, 2, nak);
      chk("ack", 16'h0000, {15'h0000, nak});
      if (s != 2'h0) mreg[s] = v;
      ports();
      rdreg(s, 1'b1);
   endtask : wrreg
   task automatic conv(input int x);
      int y;
      convData = 18'(x);
      y = int'(convData);
      convDone = 1'b1;
      mst.tick(1);
      convDone = 1'b0;
      mreg[0] = y > 32767 ? 16'h7FFF : y < -32768 ? 16'h8000 : 16'(y);
      mst.tick(1);
      ports();
   endtask : conv
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst = 1'b0;
      mst.tick(4);
      ports();
      for (int s = 0; s < 4; s++) rdreg(2'(s), 1'b1);
      for (int s = 0; s < 4; s++) wrreg(2'(s), 16'($random(seed)) & 16'h7FFF);
      rdreg(2'h3, 1'b0);
      rdreg(2'h3, 1'b0);
      // Wrong address must be refused and change nothing
      d = 16'h0000;
      mst.frame({7'h49, 1'b0}, 8'h01, d, 2, nak);
      chk("nak", 16'h0001, {15'h0000, nak});
      ports();
      // Comparatorless variant drops a low limit write, reads it as zero, keeps both limit outputs at zero
      d = 16'h1234;
      mst.frame({SB, 1'b0}, 8'h02, d, 2, nak);
      chk("ack", 16'h0000, {15'h0000, nak});
      mst.frame({SB, 1'b1}, 8'h00, d, 0, nak);
      chk("limit read", 16'h0000, d);
      chk("low off", 16'h0000, lowNc);
      chk("high off", 16'h0000, highNc);
      foreach (tbl[i]) conv(tbl[i]);
      repeat (8) conv($random(seed));
      rdreg(2'h0, 1'b1);
      // Start only from power down and only with the status bit set
      wrreg(2'h1, 16'h0183);
      chk("starts", 16'h0000, 16'(startCount));
      wrreg(2'h1, 16'h8583);
      chk("starts", 16'h0001, 16'(startCount));
      convBusy = 1'b1;
      rdreg(2'h1, 1'b0);
      wrreg(2'h1, 16'h8583);
      conv(1234);
      convBusy = 1'b0;
      // Leave single shot first: a start written in continuous mode is ignored
      wrreg(2'h1, 16'h0483);
      wrreg(2'h1, 16'h8483);
      chk("starts", 16'h0001, 16'(startCount));
      final_report();
   end
endmodule : adcr_regs_tb
`default_nettype wire
